/* File: src/tmwo_top.sv */
// tmwo_top: 8-bit timer counter with two compare channels in normal,
// clear-on-match and fast pwm modes; tick_in is a one-cycle prescaler
// enable on clock_in, all controls are same-domain plain ports.
`default_nettype none
module tmwo_top
  import tmwo_pkg::*;
#(
  parameter int WIDTH = TMWO_WIDTH
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic [2:0] waveform_mode_select_in,
  input wire logic counter_write_in,
  input wire logic [7:0] counter_write_value_in,
  input wire logic overflow_flag_clear_in,
  input wire tmwo_chan_ctrl_type channel_a_ctrl_in,
  input wire tmwo_chan_ctrl_type channel_b_ctrl_in,
  output logic [7:0] counter_value_out,
  output logic overflow_flag_out,
  output logic compare_flag_a_out,
  output logic compare_flag_b_out,
  output logic channel_a_output_out,
  output logic channel_b_output_out,
  output tmwo_pin_type channel_a_pin_out,
  output tmwo_pin_type channel_b_pin_out
);
  // the counter, compares and flags are all built for one byte
  if (WIDTH != TMWO_WIDTH) begin
    $error("tmwo_top supports an 8-bit counter only");
  end

  logic [7:0] cnt_reg, cnt_next;
  logic ovf_reg, ovf_next;
  logic blk_reg, blk_next;
  logic pwm, at_top, ovf_set;
  logic [7:0] top_value, cmp_a;
  logic match_a, match_b;

  // the pwm decode is shared by both channels; modes 1, 4, 5 and 6 unsupported
  always_comb begin
    pwm = (waveform_mode_select_in == TMWO_WGM_FAST_MAX) ||
          (waveform_mode_select_in == TMWO_WGM_FAST_REG);
    case (waveform_mode_select_in)
      TMWO_WGM_FAST_REG: top_value = cmp_a;
      default: top_value = TMWO_MAX;
    endcase
    at_top = pwm && (cnt_reg == top_value);
  end

  always_comb begin
    cnt_next = cnt_reg;
    ovf_next = ovf_reg;
    ovf_set = 1'b0;
    // a counter write masks compare matches for the following tick
    blk_next = blk_reg;
    if (tick_in) begin
      blk_next = 1'b0;
    end
    if (tick_in) begin
      case (waveform_mode_select_in)
        TMWO_WGM_CTC: begin
          if (match_a) begin
            cnt_next = TMWO_BOTTOM;
          end else begin
            cnt_next = cnt_reg + 8'h01;
          end
          ovf_set = (cnt_reg == TMWO_MAX);
        end
        TMWO_WGM_FAST_MAX, TMWO_WGM_FAST_REG: begin
          if (at_top) begin
            cnt_next = TMWO_BOTTOM;
            ovf_set = 1'b1;
          end else begin
            cnt_next = cnt_reg + 8'h01;
          end
        end
        default: begin
          cnt_next = cnt_reg + 8'h01;
          ovf_set = (cnt_reg == TMWO_MAX);
        end
      endcase
    end
    if (counter_write_in) begin
      cnt_next = counter_write_value_in;
      blk_next = 1'b1;
    end
    if (ovf_set) begin
      ovf_next = 1'b1;
    end else if (overflow_flag_clear_in) begin
      ovf_next = 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_reg <= TMWO_CNT_RESET;
      ovf_reg <= 1'b0;
      blk_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      ovf_reg <= ovf_next;
      blk_reg <= blk_next;
    end
  end

  tmwo_channel #(
    .IS_CHANNEL_A(1'b1)
  ) u_chan_a (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .tick_in(tick_in),
    .ctrl_in(channel_a_ctrl_in),
    .count_in(cnt_reg),
    .mode_in(waveform_mode_select_in),
    .pwm_in(pwm),
    .at_top_in(at_top),
    .match_block_in(blk_reg),
    .active_value_out(cmp_a),
    .match_out(match_a),
    .flag_out(compare_flag_a_out),
    .state_out(channel_a_output_out),
    .pin_out(channel_a_pin_out)
  );

  tmwo_channel #(
    .IS_CHANNEL_A(1'b0)
  ) u_chan_b (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .tick_in(tick_in),
    .ctrl_in(channel_b_ctrl_in),
    .count_in(cnt_reg),
    .mode_in(waveform_mode_select_in),
    .pwm_in(pwm),
    .at_top_in(at_top),
    .match_block_in(blk_reg),
    .active_value_out(),
    .match_out(match_b),
    .flag_out(compare_flag_b_out),
    .state_out(channel_b_output_out),
    .pin_out(channel_b_pin_out)
  );

  assign counter_value_out = cnt_reg;
  assign overflow_flag_out = ovf_reg;
endmodule
`default_nettype wire

/* File: src/tmwo_pkg.sv */
// tmwo_pkg: shared constants and carrier types for the 8-bit timer
// waveform output unit; no assumptions beyond a single clock domain.
`default_nettype none
package tmwo_pkg;
  localparam int TMWO_WIDTH = 8;
  localparam logic [7:0] TMWO_BOTTOM = 8'h00;
  localparam logic [7:0] TMWO_MAX = 8'hFF;
  localparam logic [7:0] TMWO_CNT_RESET = 8'h00;
  localparam logic [7:0] TMWO_CMP_RESET = 8'h00;
  localparam logic TMWO_OUT_RESET = 1'b0;

  // waveform_mode_select codes
  localparam logic [2:0] TMWO_WGM_NORMAL = 3'h0;
  localparam logic [2:0] TMWO_WGM_CTC = 3'h2;
  localparam logic [2:0] TMWO_WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] TMWO_WGM_FAST_REG = 3'h7;
  localparam int TMWO_WGM_TOPREG_BIT = 2;

  // compare_output_mode codes
  localparam logic [1:0] TMWO_COM_OFF = 2'h0;
  localparam logic [1:0] TMWO_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TMWO_COM_CLEAR = 2'h2;
  localparam logic [1:0] TMWO_COM_SET = 2'h3;

  // software side controls for one compare channel
  typedef struct packed {
    logic [1:0] compare_output_mode;
    logic [7:0] compare_value;
    logic compare_value_write;
    logic force_compare_strobe;
    logic compare_flag_clear;
    logic output_pin_direction_bit;
    logic port_value;
  } tmwo_chan_ctrl_type;

  // pin side of one channel
  typedef struct packed {
    logic pin_value;
    logic pin_enable;
  } tmwo_pin_type;
endpackage
`default_nettype wire

/* File: src/tmwo_channel.sv */
// tmwo_channel: one compare channel (compare register, buffer, flag,
// output state and pin override); counter and tick come from the top.
`default_nettype none
module tmwo_channel
  import tmwo_pkg::*;
#(
  parameter bit IS_CHANNEL_A = 1'b1
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire tmwo_chan_ctrl_type ctrl_in,
  input wire logic [7:0] count_in,
  input wire logic [2:0] mode_in,
  input wire logic pwm_in,
  input wire logic at_top_in,
  input wire logic match_block_in,
  output logic [7:0] active_value_out,
  output logic match_out,
  output logic flag_out,
  output logic state_out,
  output tmwo_pin_type pin_out
);
  logic [7:0] buf_reg, buf_next;
  logic [7:0] act_reg, act_next;
  logic flag_reg, flag_next;
  logic oc_reg, oc_next;
  tmwo_pin_type pin_reg, pin_next;
  logic [1:0] com;
  logic is_match;

  always_comb begin
    com = ctrl_in.compare_output_mode;
    buf_next = buf_reg;
    act_next = act_reg;
    flag_next = flag_reg;
    oc_next = oc_reg;
    is_match = (count_in == act_reg) && !match_block_in;
    if (ctrl_in.compare_value_write) begin
      buf_next = ctrl_in.compare_value;
      if (!pwm_in) begin
        act_next = ctrl_in.compare_value;
      end
    end
    if (tick_in) begin
      if (pwm_in && at_top_in) begin
        act_next = buf_reg;
      end
      if (is_match) begin
        flag_next = 1'b1;
      end
      if (!pwm_in) begin
        // mode read live: a new code acts on the next match
        if (is_match || ctrl_in.force_compare_strobe) begin
          case (com)
            TMWO_COM_TOGGLE: oc_next = ~oc_reg;
            TMWO_COM_CLEAR: oc_next = 1'b0;
            TMWO_COM_SET: oc_next = 1'b1;
            default: oc_next = oc_reg;
          endcase
        end
      end else begin
        // bottom action sits in the top-to-bottom tick
        if (at_top_in && com[1]) begin
          oc_next = (com == TMWO_COM_CLEAR);
        end else if (is_match) begin
          case (com)
            TMWO_COM_TOGGLE:
              if (IS_CHANNEL_A && mode_in[TMWO_WGM_TOPREG_BIT]) begin
                oc_next = ~oc_reg;
              end
            TMWO_COM_CLEAR: oc_next = 1'b0;
            TMWO_COM_SET: oc_next = 1'b1;
            default: oc_next = oc_reg;
          endcase
        end
      end
    end
    // set wins over a same-cycle software clear
    if (ctrl_in.compare_flag_clear && !(tick_in && is_match)) begin
      flag_next = 1'b0;
    end
    // override depends only on the mode field, direction on the bit
    pin_next.pin_value = (com != TMWO_COM_OFF) ? oc_next
                         : ctrl_in.port_value;
    pin_next.pin_enable = ctrl_in.output_pin_direction_bit;
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      buf_reg <= TMWO_CMP_RESET;
      act_reg <= TMWO_CMP_RESET;
      flag_reg <= 1'b0;
      oc_reg <= TMWO_OUT_RESET;
      pin_reg <= '0;
    end else begin
      buf_reg <= buf_next;
      act_reg <= act_next;
      flag_reg <= flag_next;
      oc_reg <= oc_next;
      pin_reg <= pin_next;
    end
  end

  assign active_value_out = act_reg;
  assign match_out = (count_in == act_reg) && !match_block_in;
  assign flag_out = flag_reg;
  assign state_out = oc_reg;
  assign pin_out = pin_reg;
endmodule
`default_nettype wire

/* File: bench/tmwo_top_sva.sv */
// tmwo_top_sva: port-level checks of the timer waveform unit.
// assumes one clock domain and the top's own port types.
`default_nettype none
module tmwo_top_sva
  import tmwo_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic [2:0] waveform_mode_select_in,
  input wire logic counter_write_in,
  input wire logic [7:0] counter_write_value_in,
  input wire tmwo_chan_ctrl_type channel_a_ctrl_in,
  input wire tmwo_chan_ctrl_type channel_b_ctrl_in,
  input wire logic [7:0] counter_value_out,
  input wire logic overflow_flag_out,
  input wire logic channel_a_output_out,
  input wire logic channel_b_output_out,
  input wire tmwo_pin_type channel_a_pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  sequence s_step(m);
    tick_in && !counter_write_in && waveform_mode_select_in == m;
  endsequence
  a_reset_zero: assert property (
    $past(reset_in) |-> counter_value_out == 8'h00 &&
    !channel_a_output_out && !channel_b_output_out)
    else $error("state not cleared");
  a_tick_gate: assert property (
    !tick_in && !counter_write_in |=> $stable(counter_value_out))
    else $error("count moved untimed");
  a_write_wins: assert property (
    counter_write_in |=> counter_value_out == $past(counter_write_value_in))
    else $error("count write lost");
  a_normal_count: assert property (
    s_step(3'h0) |=> counter_value_out == $past(counter_value_out) + 8'h01)
    else $error("bad normal count");
  a_overflow_wrap: assert property (
    tick_in && !counter_write_in && counter_value_out == 8'hFF &&
    (waveform_mode_select_in == 3'h0 || waveform_mode_select_in == 3'h2)
    |=> overflow_flag_out && counter_value_out == 8'h00)
    else $error("no wrap overflow");
  a_pwm_restart: assert property (
    s_step(3'h3) ##0 counter_value_out == 8'hFF
    |=> overflow_flag_out && counter_value_out == 8'h00)
    else $error("no pwm restart");
  a_force_now: assert property (
    tick_in && waveform_mode_select_in[1:0] != 2'h3 &&
    channel_a_ctrl_in.force_compare_strobe &&
    channel_a_ctrl_in.compare_output_mode[1] |=> channel_a_output_out ==
    $past(channel_a_ctrl_in.compare_output_mode[0]))
    else $error("force not applied");
  a_b_hold: assert property (
    channel_b_ctrl_in.compare_output_mode == 2'h0 ||
    (channel_b_ctrl_in.compare_output_mode == 2'h1 &&
    waveform_mode_select_in[1:0] == 2'h3) |=> $stable(channel_b_output_out))
    else $error("output b moved");
  a_pin_dir: assert property (
    !$past(reset_in) |-> channel_a_pin_out.pin_enable ==
    $past(channel_a_ctrl_in.output_pin_direction_bit))
    else $error("pin enable wrong");
  a_pin_source: assert property (
    !$past(reset_in) |-> channel_a_pin_out.pin_value ==
    ($past(channel_a_ctrl_in.compare_output_mode) != 2'h0 ?
    channel_a_output_out : $past(channel_a_ctrl_in.port_value)))
    else $error("pin source wrong");
endmodule
`default_nettype wire

/* File: bench/tmwo_pin_model.sv */
// tmwo_pin_model: one port pin with a pull-up on the board.
// assumes the pin struct of the top; needs no clock.
`default_nettype none
module tmwo_pin_model
  import tmwo_pkg::*;
(
  input wire tmwo_pin_type pin_in,
  output logic level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // released pin goes to the pull-up, never keeps the last value
  assign level_out = pin_in.pin_enable ? pin_in.pin_value : 1'b1;
endmodule
`default_nettype wire

/* File: bench/tmwo_top_tb.sv */
// tmwo_top_tb: directed tests of the timer waveform unit.
// assumes a 10 MHz clock; inputs change on falling edges.
`default_nettype none
module tmwo_top_tb
  import tmwo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic tick_in = 1'b0;
  logic counter_write_in = 1'b0;
  logic overflow_flag_clear_in = 1'b0;
  logic [2:0] waveform_mode_select_in = 3'h0;
  logic [7:0] counter_write_value_in = 8'h00;
  tmwo_chan_ctrl_type channel_a_ctrl_in = '0;
  tmwo_chan_ctrl_type channel_b_ctrl_in = '0;
  logic [7:0] counter_value_out;
  logic overflow_flag_out, compare_flag_a_out, compare_flag_b_out;
  logic channel_a_output_out, channel_b_output_out, level_a, level_b;
  tmwo_pin_type channel_a_pin_out, channel_b_pin_out;
  int fail_count = 0;
  int tests_run = 0;
  wire logic [7:0] flags = {4'h0, overflow_flag_out, compare_flag_a_out,
    channel_a_output_out, level_a};
  tmwo_top dut_u (.clock_in, .reset_in, .tick_in, .waveform_mode_select_in,
    .counter_write_in, .counter_write_value_in, .overflow_flag_clear_in,
    .channel_a_ctrl_in, .channel_b_ctrl_in, .counter_value_out,
    .overflow_flag_out, .compare_flag_a_out, .compare_flag_b_out,
    .channel_a_output_out, .channel_b_output_out, .channel_a_pin_out,
    .channel_b_pin_out);
  tmwo_pin_model pin_a_u (.pin_in(channel_a_pin_out), .level_out(level_a));
  tmwo_pin_model pin_b_u (.pin_in(channel_b_pin_out), .level_out(level_b));
  initial begin
    forever #50 clock_in = ~clock_in;
  end
  task check(input string name, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task state(input logic [7:0] cnt, fl);
    check("count", counter_value_out, cnt);
    check("flags", flags, fl);
  endtask
  task ticks(input int n);
    @(negedge clock_in);
    tick_in = 1'b1;
    repeat (n) @(negedge clock_in);
    tick_in = 1'b0;
  endtask
  // one task for both writes keeps the pulse timing identical
  task load(input logic to_cmp, input logic [7:0] v);
    @(negedge clock_in);
    counter_write_in = !to_cmp;
    counter_write_value_in = v;
    channel_a_ctrl_in.compare_value = v;
    channel_a_ctrl_in.compare_value_write = to_cmp;
    @(negedge clock_in);
    counter_write_in = 1'b0;
    channel_a_ctrl_in.compare_value_write = 1'b0;
  endtask
  task clr;
    @(negedge clock_in);
    overflow_flag_clear_in = 1'b1;
    channel_a_ctrl_in.compare_flag_clear = 1'b1;
    @(negedge clock_in);
    overflow_flag_clear_in = 1'b0;
    channel_a_ctrl_in.compare_flag_clear = 1'b0;
  endtask
  task pin(input logic [1:0] com, input logic dir, input logic [7:0] fl);
    channel_a_ctrl_in.compare_output_mode = com;
    channel_a_ctrl_in.output_pin_direction_bit = dir;
    repeat (2) @(negedge clock_in);
    check("pin", flags, fl);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clock_in);
    reset_in = 1'b0;
    state(8'h00, 8'h01);
    $display("test reset done");
    load(1'b0, 8'hFE);
    ticks(2);
    state(8'h00, 8'h09);
    ticks(3);
    state(8'h03, 8'h0D);
    clr;
    state(8'h03, 8'h01);
    $display("test normal done");
    for (int i = 3; i >= 1; i--) begin
      channel_a_ctrl_in.compare_output_mode = 2'(i);
      channel_a_ctrl_in.force_compare_strobe = 1'b1;
      ticks(1);
      channel_a_ctrl_in.force_compare_strobe = 1'b0;
      check("force", flags, (i != 2) ? 8'h03 : 8'h01);
    end
    $display("test force done");
    pin(2'h0, 1'b1, 8'h02);
    pin(2'h1, 1'b1, 8'h03);
    pin(2'h0, 1'b0, 8'h03);
    $display("test pin done");
    pin(2'h1, 1'b1, 8'h03);
    waveform_mode_select_in = 3'h2;
    load(1'b1, 8'h03);
    load(1'b0, 8'h00);
    ticks(4);
    state(8'h00, 8'h04);
    ticks(4);
    state(8'h00, 8'h07);
    clr;
    ticks(3);
    load(1'b1, 8'h01);
    ticks(253);
    state(8'h00, 8'h0B);
    $display("test clear on match done");
    clr;
    waveform_mode_select_in = 3'h3;
    channel_a_ctrl_in.compare_output_mode = 2'h3;
    channel_b_ctrl_in.compare_output_mode = 2'h1;
    load(1'b1, 8'h80);
    load(1'b0, 8'hFE);
    ticks(2);
    state(8'h00, 8'h08);
    clr;
    ticks(128);
    state(8'h80, 8'h00);
    ticks(1);
    state(8'h81, 8'h07);
    $display("test fast pwm done");
    // top from compare A: buffer lands at top, toggle every 3 ticks
    waveform_mode_select_in = 3'h7;
    channel_a_ctrl_in.compare_output_mode = 2'h1;
    load(1'b1, 8'h02);
    load(1'b0, 8'h80);
    ticks(4);
    state(8'h00, 8'h0C);
    ticks(3);
    state(8'h00, 8'h0F);
    check("chan b", {5'h00, compare_flag_b_out, channel_b_output_out,
      level_b}, 8'h05);
    $display("test top from register done");
    wrap_up;
  end
endmodule
bind tmwo_top tmwo_top_sva chk_u (.clock_in, .reset_in, .tick_in,
  .waveform_mode_select_in, .counter_write_in, .counter_write_value_in,
  .channel_a_ctrl_in, .channel_b_ctrl_in, .counter_value_out,
  .overflow_flag_out, .channel_a_output_out, .channel_b_output_out,
  .channel_a_pin_out);
`default_nettype wire
